// *** design/gpms_pkg.sv ***
// Purpose: Constants and carrier types for the gigabit master/slave register bank
// Assumes: 16-bit management registers addressed by 5-bit register index
// Notes: Strap decode and field positions live here only
//
// What this block does
// - Next-page receive register is read-only and shows the partner code word fields.
// - After reset it reads message-page one, code zero, other bits zero.
// - Toggle bit reads inverse of the previous toggle value.
// - Test mode field 15:13 selects normal or four tests; 101-111 reserved.
// - Manual enable bit 12 forces role from manual value; otherwise automatic.
// - Bit 11 selects slave or master, effective only with manual enable set.
// - Bit 10 single or multiport, used only when manual enable is clear.
// - Bits 9 and 8 advertise gigabit full and half duplex.
// - Manual enable, value, port type and advertise bits reset from mode straps.
// - Status bit 15 latches config fault until read; resets to zero.
// - Status bit 14 shows resolved role, one for master.
// - Status bits 13 and 12 show local and remote receiver OK.
// - Status bits 11 and 10 show partner gigabit abilities, valid with page received.
// - Bits 7:0 count idle-symbol receive errors, resetting to zero.
// - Counter clears on management read and on hardware, software or logic reset.
// - Counter saturates at all ones instead of wrapping.
// - Counter overflow is offered as an interrupt source.
// - Page-received indication latches high on a new page, zero otherwise.
package gpms_pkg;

  localparam logic [4:0] GPMS_ADDR_NP_RX = 5'h08;
  localparam logic [4:0] GPMS_ADDR_CTRL = 5'h09;
  localparam logic [4:0] GPMS_ADDR_STAT = 5'h0a;

  localparam int GPMS_BIT_TEST_HI = 15;
  localparam int GPMS_BIT_TEST_LO = 13;
  localparam int GPMS_BIT_MAN_EN = 12;
  localparam int GPMS_BIT_MAN_VAL = 11;
  localparam int GPMS_BIT_PORT = 10;
  localparam int GPMS_BIT_ADV_FD = 9;
  localparam int GPMS_BIT_ADV_HD = 8;

  localparam logic [15:0] GPMS_NP_RX_RESET = 16'h2000;
  localparam logic [2:0] GPMS_TEST_RESET = 3'h0;
  localparam logic [7:0] GPMS_IDLE_ERR_RESET = 8'h00;
  localparam logic [7:0] GPMS_IDLE_ERR_MAX = 8'hff;

  // Edges after reset release during which the control bits reload from the synchronised straps
  localparam logic [1:0] GPMS_STRAP_SETTLE = 2'h3;

  // Status register field positions
  localparam int GPMS_BIT_FAULT = 15;
  localparam int GPMS_BIT_ROLE = 14;
  localparam int GPMS_BIT_LOCAL_OK = 13;
  localparam int GPMS_BIT_REMOTE_OK = 12;
  localparam int GPMS_BIT_PTNR_FD = 11;
  localparam int GPMS_BIT_PTNR_HD = 10;
  localparam int GPMS_BIT_CNT_HI = 7;

  // Test mode codes
  typedef enum logic [2:0] {
    GPMS_TEST_NORMAL = 3'h0,
    GPMS_TEST_WAVEFORM = 3'h1,
    GPMS_TEST_JIT_MASTER = 3'h2,
    GPMS_TEST_JIT_SLAVE = 3'h3,
    GPMS_TEST_DISTORT = 3'h4
  } gpms_test_type;

  // Control register content
  typedef struct packed {
    logic [2:0] test_mode;
    logic man_en;
    logic man_val;
    logic multiport;
    logic adv_fd;
    logic adv_hd;
  } gpms_ctrl_type;

  // Strap decode of the two mode pins into control defaults
  function automatic gpms_ctrl_type gpms_strap_ctrl(input logic [1:0] mode);
    gpms_ctrl_type c;
    c = '0;
    c.test_mode = GPMS_TEST_RESET;
    c.man_en = mode[1] & mode[0];
    c.man_val = mode[1];
    c.multiport = mode[0];
    c.adv_fd = ~(mode[1] & ~mode[0]);
    c.adv_hd = ~(mode[1] & ~mode[0]);
    return c;
  endfunction : gpms_strap_ctrl

  // Link-side status inputs grouped
  typedef struct packed {
    logic ms_fault;
    logic role_master;
    logic local_rx_ok;
    logic remote_rx_ok;
    logic partner_gig_full_ability;
    logic partner_gig_half_ability;
    logic page_rx;
    logic idle_err;
  } gpms_link_type;

  // All module state
  typedef struct packed {
    logic [15:0] np_rx;
    gpms_ctrl_type ctrl;
    logic [1:0] strap_cnt;
    logic fault_lh;
    logic page_lh;
    logic [7:0] idle_cnt;
    logic ovf;
    logic [15:0] rd_data;
    gpms_link_type s1;
    gpms_link_type s2;
    logic [1:0] strap1;
    logic [1:0] strap2;
  } gpms_state_type;

endpackage : gpms_pkg

// *** design/gpms_regs.sv ***
// Purpose: Master/slave, gigabit advertisement and next-page receive registers
// Assumes: Management access arrives as one-cycle read and write strobes on sys_clk_in
// Notes: Link status pins come from other logic and are synchronised here
`timescale 1ns/1ps
module gpms_regs
  import gpms_pkg::*;
(
  input wire logic sys_clk_in, // 200 MHz clock
  input wire logic rst_in, // Async reset, high
  input wire logic soft_rst_in, // Software or logical reset pulse
  input wire logic [1:0] mode_strap_in, // Mode config strap pins
  input wire logic [4:0] reg_addr_in, // Register index
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  input wire logic [15:0] reg_wdata_in, // Write data
  output logic [15:0] reg_rdata_out, // Read data, valid cycle after strobe
  input wire logic np_load_in, // New next-page word received
  input wire logic [15:0] np_word_in, // Received code word
  input wire gpms_link_type link_in, // Link status and events
  output logic [2:0] test_mode_out, // Active test mode
  output logic role_master_out, // Role request to resolution
  output logic role_manual_out, // Manual role in force
  output logic multiport_out, // Port type for automatic resolution
  output logic adv_gig_full_out, // Advertise 1000 full
  output logic adv_gig_half_out, // Advertise 1000 half
  output logic page_rx_out, // Latched page-received indication
  output logic idle_ovf_out // Counter overflow interrupt source
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------

  // One strobe against one register index; every access decode goes through here
  function automatic logic gpms_hit(
    input logic strobe,
    input logic [4:0] addr,
    input logic [4:0] target
  );
    logic hit;
    hit = strobe && (addr == target);
    return hit;
  endfunction : gpms_hit

  // Control fields taken from a management write word
  function automatic gpms_ctrl_type gpms_ctrl_from_word(
    input logic [15:0] w
  );
    gpms_ctrl_type c;
    c = '0;
    c.test_mode = w[GPMS_BIT_TEST_HI:GPMS_BIT_TEST_LO];
    c.man_en = w[GPMS_BIT_MAN_EN];
    c.man_val = w[GPMS_BIT_MAN_VAL];
    c.multiport = w[GPMS_BIT_PORT];
    c.adv_fd = w[GPMS_BIT_ADV_FD];
    c.adv_hd = w[GPMS_BIT_ADV_HD];
    return c;
  endfunction : gpms_ctrl_from_word

  // Control register as management sees it; low byte is reserved and reads zero
  function automatic logic [15:0] gpms_ctrl_word(
    input gpms_ctrl_type c
  );
    logic [15:0] w;
    w = 16'h0000;
    w[GPMS_BIT_TEST_HI:GPMS_BIT_TEST_LO] = c.test_mode;
    w[GPMS_BIT_MAN_EN] = c.man_en;
    w[GPMS_BIT_MAN_VAL] = c.man_val;
    w[GPMS_BIT_PORT] = c.multiport;
    w[GPMS_BIT_ADV_FD] = c.adv_fd;
    w[GPMS_BIT_ADV_HD] = c.adv_hd;
    return w;
  endfunction : gpms_ctrl_word

  // Status register word; partner abilities are masked until a page is in
  function automatic logic [15:0] gpms_stat_word(
    input logic fault,
    input logic page,
    input gpms_link_type live,
    input logic [7:0] cnt
  );
    logic [15:0] w;
    w = 16'h0000;
    w[GPMS_BIT_FAULT] = fault;
    w[GPMS_BIT_ROLE] = live.role_master;
    w[GPMS_BIT_LOCAL_OK] = live.local_rx_ok;
    w[GPMS_BIT_REMOTE_OK] = live.remote_rx_ok;
    // Masking keeps stale abilities from an old negotiation out of view
    w[GPMS_BIT_PTNR_FD] = page & live.partner_gig_full_ability;
    w[GPMS_BIT_PTNR_HD] = page & live.partner_gig_half_ability;
    w[GPMS_BIT_CNT_HI:0] = cnt;
    return w;
  endfunction : gpms_stat_word

  // ----------------------------------------
  // Event helpers
  // ----------------------------------------

  // Latched-high bit: a read returns it to the live level, otherwise an event sets it
  function automatic logic gpms_latch_next(
    input logic rd_clr,
    input logic ev,
    input logic cur
  );
    logic nxt;
    nxt = cur;
    if (rd_clr) begin
      // Taking the live level means an event in the read cycle is not lost
      nxt = ev;
    end else if (ev) begin
      nxt = 1'b1;
    end
    return nxt;
  endfunction : gpms_latch_next

  // Saturating idle error count with clear on read and on soft reset
  function automatic logic [7:0] gpms_cnt_next(
    input logic rd_clr,
    input logic soft_clr,
    input logic ev,
    input logic [7:0] cnt
  );
    logic [7:0] nxt;
    nxt = cnt;
    if (soft_clr) begin
      nxt = GPMS_IDLE_ERR_RESET;
    end else if (rd_clr) begin
      // An error in the read cycle starts the new count so it is never dropped
      nxt = ev ? 8'h01 : GPMS_IDLE_ERR_RESET;
    end else if (ev && (cnt != GPMS_IDLE_ERR_MAX)) begin
      nxt = cnt + 8'h01;
    end
    // At all ones further errors leave the count where it is
    return nxt;
  endfunction : gpms_cnt_next

  // Overflow flag for the interrupt controller; sticky until read or soft reset
  function automatic logic gpms_ovf_next(
    input logic rd_clr,
    input logic soft_clr,
    input logic ev,
    input logic [7:0] cnt,
    input logic cur
  );
    logic nxt;
    nxt = cur;
    if (rd_clr || soft_clr) begin
      nxt = 1'b0;
    end else if (ev && (cnt == GPMS_IDLE_ERR_MAX)) begin
      nxt = 1'b1;
    end
    return nxt;
  endfunction : gpms_ovf_next

  // ----------------------------------------
  // State and decode signals
  // ----------------------------------------

  // Whole module state; q is registered, d is its next value
  gpms_state_type q, d;
  logic rd_np, rd_ctrl, rd_stat, wr_ctrl;
  logic idle_ev, page_ev, fault_ev;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;

    // Access decode, taken on the edge where the strobe is high
    rd_np = gpms_hit(reg_rd_in, reg_addr_in, GPMS_ADDR_NP_RX);
    rd_ctrl = gpms_hit(reg_rd_in, reg_addr_in, GPMS_ADDR_CTRL);
    rd_stat = gpms_hit(reg_rd_in, reg_addr_in, GPMS_ADDR_STAT);
    wr_ctrl = gpms_hit(reg_wr_in, reg_addr_in, GPMS_ADDR_CTRL);

    // Two flops before any logic sees the pins
    d.s1 = link_in;
    d.s2 = q.s1;
    d.strap1 = mode_strap_in;
    d.strap2 = q.strap1;

    // Events are read only from the second flop
    idle_ev = q.s2.idle_err;
    page_ev = q.s2.page_rx;
    fault_ev = q.s2.ms_fault;

    // Straps reload the control bits until the synchroniser holds the pin value;
    // writes in those first few cycles are dropped, a limit software must respect
    if (q.strap_cnt != GPMS_STRAP_SETTLE) begin
      d.strap_cnt = q.strap_cnt + 2'h1;
      d.ctrl = gpms_strap_ctrl(q.strap2);
    end else if (wr_ctrl) begin
      d.ctrl = gpms_ctrl_from_word(reg_wdata_in);
    end

    // Partner word; toggle already carries inverse-of-previous meaning
    if (np_load_in) begin
      d.np_rx = np_word_in;
    end

    // Latched-high status bits
    d.fault_lh = gpms_latch_next(rd_stat, fault_ev, q.fault_lh);
    d.page_lh = gpms_latch_next(rd_stat, page_ev, q.page_lh);

    // Idle error count and its overflow flag
    d.idle_cnt = gpms_cnt_next(rd_stat, soft_rst_in, idle_ev, q.idle_cnt);
    d.ovf = gpms_ovf_next(rd_stat, soft_rst_in, idle_ev, q.idle_cnt, q.ovf);

    // Registered read data; zero when no read or an unmapped index
    d.rd_data = 16'h0000;
    if (rd_np) begin
      d.rd_data = q.np_rx;
    end else if (rd_ctrl) begin
      d.rd_data = gpms_ctrl_word(q.ctrl);
    end else if (rd_stat) begin
      d.rd_data = gpms_stat_word(q.fault_lh, q.page_lh, q.s2, q.idle_cnt);
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
      q.np_rx <= GPMS_NP_RX_RESET;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // Read data straight from its flop
  assign reg_rdata_out = q.rd_data;

  // Test mode goes out as written; reserved codes are left to the waveform logic
  assign test_mode_out = q.ctrl.test_mode;

  // Manual value only counts when manual enable is set
  assign role_manual_out = q.ctrl.man_en;
  assign role_master_out = q.ctrl.man_en & q.ctrl.man_val;

  // Port type only steers automatic resolution
  assign multiport_out = ~q.ctrl.man_en & q.ctrl.multiport;

  // Gigabit advertisement bits
  assign adv_gig_full_out = q.ctrl.adv_fd;
  assign adv_gig_half_out = q.ctrl.adv_hd;

  // Latched indications
  assign page_rx_out = q.page_lh;
  assign idle_ovf_out = q.ovf;

endmodule : gpms_regs

// *** tb/gpms_smc.sv ***
// Purpose: Management controller model
// Assumes: Tasks entered at a falling edge
// Notes: Released address and data lines show inverted values
`timescale 1ns/1ps
module gpms_smc (
  input wire logic clk_in, // Clock
  input wire logic [15:0] reg_rdata_in, // Rdata
  output logic [4:0] reg_addr_out, // Index
  output logic reg_wr_out, // Write
  output logic reg_rd_out, // Read
  output logic [15:0] reg_wdata_out // Wdata
);
  initial {reg_addr_out, reg_wr_out, reg_rd_out, reg_wdata_out} = '0;
  // One-cycle strobe, then an idle cycle so calls never collide
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = w;
    reg_rd_out = ~w;
    @(negedge clk_in);
    q = reg_rdata_in;
    {reg_wr_out, reg_rd_out} = 2'h0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
    @(negedge clk_in);
  endtask : acc
endmodule : gpms_smc

// *** tb/gpms_sva.sv ***
// Purpose: Port checks for the master/slave register bank
// Assumes: One clock, async high reset
// Notes: Bound from the testbench top
`timescale 1ns/1ps
module gpms_sva
  import gpms_pkg::*;
(
  input wire logic sys_clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic soft_rst_in, // Soft reset
  input wire logic [4:0] reg_addr_in, // Index
  input wire logic reg_wr_in, // Write
  input wire logic reg_rd_in, // Read
  input wire logic [15:0] reg_wdata_in, // Wdata
  input wire logic [15:0] reg_rdata_out, // Rdata
  input wire logic np_load_in, // Page load
  input wire logic [15:0] np_word_in, // Page word
  input wire gpms_link_type link_in, // Link
  input wire logic [2:0] test_mode_out, // Test
  input wire logic role_master_out, // Master
  input wire logic role_manual_out, // Manual
  input wire logic multiport_out, // Port type
  input wire logic adv_gig_full_out, // Adv full
  input wire logic adv_gig_half_out, // Adv half
  input wire logic idle_ovf_out // Overflow
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_ctrl_wr; reg_wr_in && reg_addr_in == GPMS_ADDR_CTRL; endsequence
  sequence s_stat_rd; reg_rd_in && reg_addr_in == GPMS_ADDR_STAT && !link_in.idle_err; endsequence
  rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
    else $error("read data not idle");
  np_load_a: assert property (np_load_in ##1 (reg_rd_in && reg_addr_in == GPMS_ADDR_NP_RX)
    |=> reg_rdata_out == $past(np_word_in, 2)) else $error("page word wrong");
  test_wr_a: assert property (s_ctrl_wr |=> test_mode_out == $past(reg_wdata_in[15:13]))
    else $error("test mode wrong");
  role_wr_a: assert property (s_ctrl_wr |=> role_manual_out == $past(reg_wdata_in[12])
    && role_master_out == $past(reg_wdata_in[12] & reg_wdata_in[11])
    && multiport_out == $past(~reg_wdata_in[12] & reg_wdata_in[10])) else $error("role wrong");
  adv_wr_a: assert property (s_ctrl_wr |=> {adv_gig_full_out, adv_gig_half_out} == $past(reg_wdata_in[9:8]))
    else $error("advertise wrong");
  ro_write_a: assert property (reg_wr_in && reg_addr_in != GPMS_ADDR_CTRL |=> $stable(test_mode_out))
    else $error("read-only write took");
  ovf_sticky_a: assert property (idle_ovf_out && !soft_rst_in && !(reg_rd_in && reg_addr_in == GPMS_ADDR_STAT)
    |=> idle_ovf_out) else $error("overflow dropped");
  cnt_clear_a: assert property (!link_in.idle_err [*3] ##1 s_stat_rd ##1 !link_in.idle_err ##1 s_stat_rd
    |=> reg_rdata_out[7:0] == 8'h00) else $error("count not cleared");
endmodule : gpms_sva

// *** tb/test_gpms_regs.sv ***
// Purpose: Self-checking bench for the register bank
// Assumes: Straps tied to mode 3
// Notes: Expected words built from bench state
`timescale 1ns/1ps
module test_gpms_regs;
  import gpms_pkg::*;
  logic sys_clk_in = 0, rst_in = 1, soft_rst_in = 0, np_load_in = 0, reg_wr_in, reg_rd_in;
  logic [1:0] mode_strap_in = 2'h3;
  logic [4:0] reg_addr_in;
  logic [15:0] np_word_in = 16'h0000, reg_wdata_in, reg_rdata_out, q, wd;
  gpms_link_type link_in = '0;
  logic [2:0] test_mode_out;
  logic role_master_out, role_manual_out, multiport_out, adv_gig_full_out, adv_gig_half_out, page_rx_out, idle_ovf_out;
  int err_total = 0, num_checks = 0, i;
  integer seed = 66;
  always #2.5 sys_clk_in = ~sys_clk_in;
  gpms_regs DUT (.*);
  gpms_smc SMC (.clk_in(sys_clk_in), .reg_rdata_in(reg_rdata_out), .reg_addr_out(reg_addr_in),
    .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in), .reg_wdata_out(reg_wdata_in));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic idle(input int n, input int hi);
    link_in.idle_err = 1'b1;
    repeat (hi) @(negedge sys_clk_in);
    link_in.idle_err = 1'b0;
    repeat (n) @(negedge sys_clk_in);
  endtask : idle
  task automatic close_out();
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // Guard against a hang
  initial begin
    #100000;
    err_total++;
    close_out();
  end
  // Main sequence at falling edges
  initial begin
    repeat (5) @(negedge sys_clk_in);
    rst_in = 0;
    @(negedge sys_clk_in);
    SMC.acc(0, 5'h08, 16'h0, q); chk(q, 16'h2000);
    SMC.acc(0, 5'h09, 16'h0, q); chk(q, 16'h1f00);
    chk({14'h0000, role_master_out, multiport_out}, 16'h0002);
    SMC.acc(1, 5'h08, 16'hffff, q); SMC.acc(0, 5'h08, 16'h0, q); chk(q, 16'h2000);
    for (i = 0; i < 2; i++) begin
      np_word_in = i ? 16'h2155 : 16'h8f5a;
      np_load_in = 1;
      @(negedge sys_clk_in);
      np_load_in = 0;
      SMC.acc(0, 5'h08, 16'h0, q); chk(q, np_word_in);
    end
    for (i = 0; i < 5; i++) begin
      wd = {i[2:0], 13'($random(seed))};
      if (i > 0) wd[11] = 1'b0;
      SMC.acc(1, 5'h09, wd, q); SMC.acc(0, 5'h09, 16'h0, q); chk(q, wd & 16'hff00);
      chk({test_mode_out, role_manual_out, role_master_out, multiport_out, adv_gig_full_out, adv_gig_half_out},
        {wd[15:12], wd[12] & wd[11], ~wd[12] & wd[10], wd[9:8]});
    end
    idle(4, 5); SMC.acc(0, 5'h0a, 16'h0, q); chk(q, 16'h0005);
    idle(4, 300); chk({15'h0000, idle_ovf_out}, 16'h0001); SMC.acc(0, 5'h0a, 16'h0, q); chk(q, 16'h00ff);
    SMC.acc(0, 5'h0a, 16'h0, q); chk(q, 16'h0000); chk({15'h0000, idle_ovf_out}, 16'h0000);
    idle(4, 3); soft_rst_in = 1; @(negedge sys_clk_in); soft_rst_in = 0;
    SMC.acc(0, 5'h0a, 16'h0, q); chk(q, 16'h0000);
    link_in = 8'he6;
    @(negedge sys_clk_in);
    link_in = 8'h68;
    repeat (4) @(negedge sys_clk_in);
    chk({15'h0000, page_rx_out}, 16'h0001); SMC.acc(0, 5'h0a, 16'h0, q); chk(q, 16'he800);
    SMC.acc(0, 5'h0a, 16'h0, q); chk(q, 16'h6000);
    SMC.acc(0, 5'h1f, 16'h0, q); chk(q, 16'h0000);
    close_out();
  end
endmodule : test_gpms_regs
bind gpms_regs gpms_sva CHK (.*);
